// >>> inc/pms_consts.vh
/*
 * constants for the power mode sequencer: mode codes, timer widths, reset values.
 * assumes inclusion by bare name from src/ with the inc/ folder on the include path.
 */
// Behaviour
// - four modes: active, idle, sleep, deep off
// - inactivity period elapsed steps one mode down
// - activity returns straight to active mode
// - deep off cuts core and amplifier supplies
// - always-on domain stays up, wakes chip
// - separate tx, rx, pll, amplifier power-downs
// - low-power connection: slow clock, timed wake
// - radio enabled only during packet phases
// - triggers from software or packet handling
// - firmware may disable regulator in deep off
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

`define PMS_MODE_W 2
`define PMS_MODE_ACTIVE 2'h0
`define PMS_MODE_IDLE 2'h1
`define PMS_MODE_SLEEP 2'h2
`define PMS_MODE_DEEP_OFF 2'h3
`define PMS_TMR_W 32
`define PMS_TMR_RST 32'h00000000
`define PMS_WAKE_W 32
`define PMS_WAKE_RST 32'h00000000
`define PMS_TMR_INC 32'h00000001
`define PMS_SUPPLY_RST 1'h1
`define PMS_AON_ON 1'h1
`define PMS_LP_RST 1'h0
`define PMS_PD_RST 1'h1
`define PMS_PATH_N 4
`define PMS_PATH_TX 0
`define PMS_PATH_RX 1
`define PMS_PATH_PLL 2
`define PMS_PATH_PA 3

`endif

// >>> src/pms_power_mode_sequencer.v
/*
 * power mode sequencer: steps the chip down through idle, sleep and deep
 * power-off on inactivity, wakes straight to active on activity, drives the
 * supply enables and the transceiver power-down lines.
 * assumes all inputs synchronous to clk_in; clk_in is the always-on clock that
 * keeps running (from the low-power oscillator) while the core is powered off.
 */
`include "pms_consts.vh"

module pms_power_mode_sequencer (
	input wire clk_in,
	input wire rst_in,
	input wire activity_in,
	input wire [31:0] inactivity_period_in,
	input wire sw_mode_req_in,
	input wire [1:0] sw_mode_in,
	input wire regulator_off_en_in,
	input wire lp_conn_req_in,
	input wire [31:0] lp_wake_period_in,
	input wire pkt_tx_phase_in,
	input wire pkt_rx_phase_in,
	output reg [1:0] mode_out,
	output reg core_supply_output_en_out,
	output reg amplifier_supply_en_out,
	output reg regulator_en_out,
	output reg always_on_io_domain_en_out,
	output reg lp_clk_sel_out,
	output reg lp_wake_out,
	output reg tx_pd_out,
	output reg rx_pd_out,
	output reg pll_pd_out,
	output reg pa_pd_out
);

	// =========================================================
	// state
	reg [1:0] mode_ff;
	reg [31:0] idle_cnt_ff;
	reg lp_conn_ff;
	reg [31:0] wake_cnt_ff;

	reg [1:0] nxt_mode;
	reg [31:0] nxt_idle_cnt;
	reg nxt_lp_conn;
	reg [31:0] nxt_wake_cnt;
	reg nxt_lp_wake;

	// decodes shared by the output logic
	function is_deep;
		input [1:0] m;
		begin
			is_deep = (m == `PMS_MODE_DEEP_OFF);
		end
	endfunction

	function is_active;
		input [1:0] m;
		begin
			is_active = (m == `PMS_MODE_ACTIVE);
		end
	endfunction

	// shared by the inactivity and timed-wake counters; a period of 0 or 1
	// expires on every cycle rather than never, and the extra bit stops a wrap
	function tmr_expired;
		input [31:0] cnt;
		input [31:0] period;
		begin
			tmr_expired = ({1'h0, cnt} + {1'h0, `PMS_TMR_INC}) >= {1'h0, period};
		end
	endfunction

	function [31:0] tmr_next;
		input [31:0] cnt;
		begin
			tmr_next = cnt + `PMS_TMR_INC;
		end
	endfunction

	// =========================================================
	// mode sequencing
	always @* begin
		nxt_mode = mode_ff;
		nxt_idle_cnt = idle_cnt_ff;
		nxt_lp_conn = lp_conn_ff;
		nxt_wake_cnt = wake_cnt_ff;
		nxt_lp_wake = 1'h0;
		if (activity_in) begin
			nxt_mode = `PMS_MODE_ACTIVE;
			nxt_idle_cnt = `PMS_TMR_RST;
		end else if (sw_mode_req_in) begin
			nxt_mode = sw_mode_in;
			nxt_idle_cnt = `PMS_TMR_RST;
		end else begin
			case (mode_ff)
				`PMS_MODE_ACTIVE, `PMS_MODE_IDLE, `PMS_MODE_SLEEP: begin
					if (tmr_expired(idle_cnt_ff, inactivity_period_in)) begin
						nxt_mode = mode_ff + 2'h1;
						nxt_idle_cnt = `PMS_TMR_RST;
					end else begin
						nxt_idle_cnt = tmr_next(idle_cnt_ff);
					end
				end
				`PMS_MODE_DEEP_OFF: begin
					nxt_idle_cnt = `PMS_TMR_RST;
				end
				default: begin
					nxt_mode = `PMS_MODE_ACTIVE;
				end
			endcase
		end
		// low-power connection timed wake
		// applied last on purpose: the timed wake overrides any step-down above
		if (activity_in || !lp_conn_req_in) begin
			nxt_lp_conn = `PMS_LP_RST;
			nxt_wake_cnt = `PMS_WAKE_RST;
		end else if (!lp_conn_ff) begin
			nxt_lp_conn = !is_active(mode_ff);
			nxt_wake_cnt = `PMS_WAKE_RST;
		end else if (tmr_expired(wake_cnt_ff, lp_wake_period_in)) begin
			nxt_wake_cnt = `PMS_WAKE_RST;
			nxt_lp_wake = 1'h1;
			nxt_lp_conn = `PMS_LP_RST;
			nxt_mode = `PMS_MODE_ACTIVE;
		end else begin
			nxt_wake_cnt = tmr_next(wake_cnt_ff);
		end
	end

	// =========================================================
	// state registers
	// the inactivity counter restarts on activity, a software request or a step down, but a timed wake to active keeps its count
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_ff <= `PMS_MODE_ACTIVE;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_cnt_ff <= `PMS_TMR_RST;
		end else begin
			idle_cnt_ff <= nxt_idle_cnt;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lp_conn_ff <= `PMS_LP_RST;
		end else begin
			lp_conn_ff <= nxt_lp_conn;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wake_cnt_ff <= `PMS_WAKE_RST;
		end else begin
			wake_cnt_ff <= nxt_wake_cnt;
		end
	end

	// =========================================================
	// next output values, following the next mode so outputs track mode_out
	reg nxt_core_en;
	reg nxt_amp_en;
	reg nxt_reg_en;
	reg nxt_aon_en;
	wire [`PMS_PATH_N-1:0] path_need;
	wire [`PMS_PATH_N-1:0] nxt_pd;

	always @* begin
		nxt_core_en = !is_deep(nxt_mode);
		nxt_amp_en = !is_deep(nxt_mode);
		nxt_reg_en = !(is_deep(nxt_mode) && regulator_off_en_in);
		nxt_aon_en = `PMS_AON_ON;
	end

	// =========================================================
	// radio path power-downs
	// separate per-path controls
	assign path_need[`PMS_PATH_TX] = pkt_tx_phase_in;
	assign path_need[`PMS_PATH_RX] = pkt_rx_phase_in;
	// the synthesizer has to run for either direction
	assign path_need[`PMS_PATH_PLL] = pkt_tx_phase_in | pkt_rx_phase_in;
	assign path_need[`PMS_PATH_PA] = pkt_tx_phase_in;

	genvar pd_idx;
	generate
		for (pd_idx = 0; pd_idx < `PMS_PATH_N; pd_idx = pd_idx + 1) begin : g_pd
			assign nxt_pd[pd_idx] = !(is_active(nxt_mode) && path_need[pd_idx]);
		end
	endgenerate

	// =========================================================
	// mode and supply outputs
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_out <= `PMS_MODE_ACTIVE;
		end else begin
			mode_out <= nxt_mode;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			core_supply_output_en_out <= `PMS_SUPPLY_RST;
		end else begin
			core_supply_output_en_out <= nxt_core_en;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			amplifier_supply_en_out <= `PMS_SUPPLY_RST;
		end else begin
			amplifier_supply_en_out <= nxt_amp_en;
		end
	end

	// keeping the regulator on in deep off costs leakage but wakes faster
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			regulator_en_out <= `PMS_SUPPLY_RST;
		end else begin
			regulator_en_out <= nxt_reg_en;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			always_on_io_domain_en_out <= `PMS_AON_ON;
		end else begin
			always_on_io_domain_en_out <= nxt_aon_en;
		end
	end

	// =========================================================
	// low-power clock select and timed wake pulse
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lp_clk_sel_out <= `PMS_LP_RST;
		end else begin
			lp_clk_sel_out <= nxt_lp_conn;
		end
	end

	// one cycle only: nxt_lp_wake clears the connection that raised it
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lp_wake_out <= `PMS_LP_RST;
		end else begin
			lp_wake_out <= nxt_lp_wake;
		end
	end

	// =========================================================
	// radio power-down outputs
	// reset leaves every path powered down until a packet asks for it
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_pd_out <= `PMS_PD_RST;
		end else begin
			tx_pd_out <= nxt_pd[`PMS_PATH_TX];
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_pd_out <= `PMS_PD_RST;
		end else begin
			rx_pd_out <= nxt_pd[`PMS_PATH_RX];
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pll_pd_out <= `PMS_PD_RST;
		end else begin
			pll_pd_out <= nxt_pd[`PMS_PATH_PLL];
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pa_pd_out <= `PMS_PD_RST;
		end else begin
			pa_pd_out <= nxt_pd[`PMS_PATH_PA];
		end
	end

endmodule

// >>> verif/pms_assertions.sv
/* port assertions for the power mode sequencer.
   assumes a bind from the bench top onto the sequencer. */
module pms_checker (
	input logic clk_in, rst_in, activity_in, sw_mode_req_in, lp_conn_req_in,
	input logic [1:0] sw_mode_in,
	input logic [1:0] mode_out,
	input logic core_supply_output_en_out, amplifier_supply_en_out, regulator_en_out,
	input logic always_on_io_domain_en_out, lp_clk_sel_out, lp_wake_out,
	input logic tx_pd_out, rx_pd_out, pll_pd_out, pa_pd_out
);
	timeunit 1ns; timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_quiet; !activity_in && !sw_mode_req_in && !lp_conn_req_in && !lp_clk_sel_out; endsequence
	property p_step;
		s_quiet |=> (mode_out == $past(mode_out)) ||
			($past(mode_out) != 2'h3 && mode_out == $past(mode_out) + 2'h1);
	endproperty
	a_step: assert property (p_step) else $error("mode moved more than one step");
	property p_wake; activity_in |=> mode_out == 2'h0; endproperty
	a_wake: assert property (p_wake) else $error("activity did not wake");
	property p_power; activity_in |=> core_supply_output_en_out && amplifier_supply_en_out; endproperty
	a_power: assert property (p_power) else $error("supplies off after activity");
	property p_deep; mode_out == 2'h3 |-> !core_supply_output_en_out && !amplifier_supply_en_out; endproperty
	a_deep: assert property (p_deep) else $error("supplies on in deep off");
	property p_aon; always_on_io_domain_en_out; endproperty
	a_aon: assert property (p_aon) else $error("always-on domain dropped");
	property p_pd; mode_out != 2'h0 |-> tx_pd_out && rx_pd_out && pll_pd_out && pa_pd_out; endproperty
	a_pd: assert property (p_pd) else $error("radio powered outside active");
	property p_reg; mode_out != 2'h3 |-> regulator_en_out; endproperty
	a_reg: assert property (p_reg) else $error("regulator off outside deep off");
	property p_sw; sw_mode_req_in && !activity_in && !lp_clk_sel_out |=> mode_out == $past(sw_mode_in); endproperty
	a_sw: assert property (p_sw) else $error("software mode not taken");
	property p_lpw; lp_wake_out |-> mode_out == 2'h0 && !lp_clk_sel_out; endproperty
	a_lpw: assert property (p_lpw) else $error("timed wake not active");
	property p_lpw1; lp_wake_out |=> !lp_wake_out; endproperty
	a_lpw1: assert property (p_lpw1) else $error("timed wake longer than one cycle");
endmodule

// >>> verif/pms_radio_model.sv
/* radio partner: one packet, two cycles of tx phase then two of rx.
   assumes pkt_go_in is held one cycle by the bench. */
module pms_radio_model (
	input logic clk_in, pkt_go_in,
	output logic tx_phase_out, rx_phase_out
);
	timeunit 1ns; timeprecision 1ns;
	logic [2:0] cnt_ff = 3'h0;
	always @(posedge clk_in) cnt_ff <= pkt_go_in ? 3'h4 : cnt_ff - (cnt_ff != 3'h0);
	assign tx_phase_out = cnt_ff >= 3'h3;
	assign rx_phase_out = cnt_ff inside {3'h1, 3'h2};
endmodule

// >>> verif/test_power_mode_sequencer.sv
/* self-checking bench for the power mode sequencer.
   assumes period 3 (1 for one step) and timed wake 2; inputs change on falling edges. */
module test_power_mode_sequencer;
	timeunit 1ns; timeprecision 1ns;
	logic clk_in = 0, rst_in = 1, act = 0, swr = 0, roff = 0, lpr = 0, go = 0, tx, rx;
	logic [1:0] swm = 2'h0;
	logic [31:0] per = 32'h3, wake = 32'h2;
	wire [1:0] mode;
	wire core, amp, reg_en, aon, lps, lpw, txp, rxp, pllp, pap;
	int n_fail = 0, compares = 0;
	always #5 clk_in = ~clk_in;
	pms_radio_model radio (.clk_in(clk_in), .pkt_go_in(go), .tx_phase_out(tx), .rx_phase_out(rx));
	pms_power_mode_sequencer dut (.clk_in(clk_in), .rst_in(rst_in), .activity_in(act),
		.inactivity_period_in(per), .sw_mode_req_in(swr), .sw_mode_in(swm),
		.regulator_off_en_in(roff), .lp_conn_req_in(lpr), .lp_wake_period_in(wake),
		.pkt_tx_phase_in(tx), .pkt_rx_phase_in(rx), .mode_out(mode),
		.core_supply_output_en_out(core), .amplifier_supply_en_out(amp), .regulator_en_out(reg_en),
		.always_on_io_domain_en_out(aon), .lp_clk_sel_out(lps), .lp_wake_out(lpw),
		.tx_pd_out(txp), .rx_pd_out(rxp), .pll_pd_out(pllp), .pa_pd_out(pap));
	task automatic check(string what, logic [1:0] exp, logic [1:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h got %h", what, exp, got);
		end
	endtask
	task automatic ticks(int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic stop_test;
		if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic do_reset;
		rst_in = 1;
		ticks(2);
		check("rst mode", 2'h0, mode);
		check("rst supplies", 2'h3, {amp, core});
		check("rst aon reg", 2'h3, {aon, reg_en});
		check("rst lp", 2'h0, {lpw, lps});
		check("rst tx rx pd", 2'h3, {txp, rxp});
		check("rst pll pa pd", 2'h3, {pllp, pap});
		rst_in = 0;
	endtask
	task automatic pulse_act;
		act = 1;
		ticks(1);
		act = 0;
	endtask
	task automatic run_descent;
		pulse_act();
		ticks(2);
		check("hold", 2'h0, mode);
		ticks(1);
		check("idle", 2'h1, mode);
		ticks(3);
		check("sleep", 2'h2, mode);
		ticks(3);
		check("deep", 2'h3, mode);
		check("supplies", 2'h0, {amp, core});
		check("aon reg", 2'h3, {aon, reg_en});
		roff = 1;
		ticks(1);
		check("aon reg off", 2'h2, {aon, reg_en});
		act = 1;
		ticks(1);
		act = 0;
		roff = 0;
		check("wake", 2'h0, mode);
		check("supplies on", 2'h3, {amp, core});
	endtask
	task automatic run_restart;
		pulse_act();
		ticks(2);
		pulse_act();
		ticks(2);
		check("restart hold", 2'h0, mode);
		ticks(1);
		check("restart idle", 2'h1, mode);
		per = 32'h1;
		pulse_act();
		ticks(1);
		check("period one", 2'h1, mode);
		per = 32'h3;
	endtask
	task automatic run_sw;
		for (int i = 3; i >= 0; i--) begin
			swr = 1;
			swm = i[1:0];
			ticks(1);
			check("sw mode", i[1:0], mode);
		end
		swm = 2'h3;
		ticks(1);
		swr = 0;
		check("sw deep supplies", 2'h0, {amp, core});
		do_reset();
	endtask
	task automatic run_radio;
		act = 1;
		go = 1;
		ticks(1);
		go = 0;
		ticks(1);
		check("tx phase", 2'h1, {txp, rxp});
		check("tx pll pa", 2'h0, {pllp, pap});
		ticks(2);
		check("rx phase", 2'h2, {txp, rxp});
		check("rx pll pa", 2'h1, {pllp, pap});
		ticks(2);
		check("no packet", 2'h3, {txp, rxp});
		check("no packet pll pa", 2'h3, {pllp, pap});
		act = 0;
	endtask
	task automatic run_lp;
		swr = 1;
		swm = 2'h1;
		ticks(1);
		swr = 0;
		lpr = 1;
		ticks(1);
		check("lp clock", 2'h1, {lpw, lps});
		ticks(2);
		lpr = 0;
		check("lp wake", 2'h2, {lpw, lps});
		check("lp mode", 2'h0, mode);
		ticks(1);
		check("lp wake pulse", 2'h0, {lpw, lps});
	endtask
	initial begin
		ticks(3);
		do_reset();
		run_descent();
		run_restart();
		run_sw();
		run_radio();
		run_lp();
		stop_test();
	end
endmodule
bind pms_power_mode_sequencer pms_checker chk (.*);
